// file: src/adcps_pkg.sv
// Package for the converter priority, monitor and sequencer block
package adcps_pkg;
  localparam int RES_W = 10;
  localparam int CH_W = 4;
  localparam int PAIR_W = 3;
  localparam int NPAIR = 8;
  // Conversion clock periods per single conversion
  localparam int CONV_TICKS = 2;
  // Full conversion clock periods of sync after the aligning tick
  localparam int FIRST_TICKS = 2;
  // Prescaler tap codes
  localparam logic [2:0] TAP_DIV1 = 3'h0;
  localparam logic [2:0] TAP_DIV2 = 3'h1;
  localparam logic [2:0] TAP_DIV4 = 3'h2;
  localparam logic [2:0] TAP_DIV8 = 3'h3;
  localparam logic [2:0] TAP_DIV16 = 3'h4;
  localparam logic [1:0] ITM_EVERY1 = 2'h0;
  localparam logic [1:0] ITM_EVERY4 = 2'h1;
  localparam logic [1:0] ITM_EVERY8 = 2'h2;
  localparam logic [2:0] LAST_PAIR4 = 3'h3;
  localparam logic [2:0] LAST_PAIR8 = 3'h7;
  localparam int TRIG_W = 4;
  // Conversion result with its destination pair
  typedef struct packed {
    logic [PAIR_W-1:0] pair;
    logic [RES_W-1:0]  data;
  } adcps_store_s;
endpackage : adcps_pkg

// file: src/adcps_prescaler.sv
// Prescaler producing the conversion clock enable pulse
`timescale 1ns/1ns
`default_nettype none
module adcps_prescaler (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [2:0] tap_sel,
  output logic            tick
);
  import adcps_pkg::*;
  logic [3:0] cnt_reg;
  logic       hit;
  // Selected tap fires when its low counter bits are all ones
  assign hit = (tap_sel == TAP_DIV1) ? 1'b1 :
               (tap_sel == TAP_DIV2) ? (cnt_reg[0] == 1'b1) :
               (tap_sel == TAP_DIV4) ? (cnt_reg[1:0] == 2'h3) :
               (tap_sel == TAP_DIV8) ? (cnt_reg[2:0] == 3'h7) :
               (cnt_reg == 4'hF);
  // Free running divider
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= 4'h0;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      tick    <= hit; // RQ10
    end
  end
endmodule : adcps_prescaler
`default_nettype wire

// file: src/adcps_top.sv
// Priority conversion, compare monitor and result placement sequencer
// Overview of operation
// [RQ1] Priority start by software bit or trigger
// [RQ2] Finish current normal conversion, then priority
// [RQ3] Priority result to own pair, interrupt
// [RQ4] Resume normal with next step afterwards
// [RQ5] Ignore priority triggers while priority busy
// [RQ6] Monitor interrupt on compare condition match
// [RQ7] Compare only when monitored pair written
// [RQ8] Monitored pair flags always read set; here set only by a write into the watched pair while the monitor is enabled
// [RQ9] One conversion takes two conversion clocks
// [RQ10] Conversion clock from five prescaler taps
// [RQ11] Software keeps conversion clock under limit
// [RQ12] First result after start needs longer latency
// [RQ13] Fixed repeat stores pairs by timing field
// [RQ14] Other modes store channel modulo eight
// [RQ15] Priority done sets end, clears busy
// [RQ16] Timing field picks interrupt every 1/4/8
// [RQ17] Polarity one means greater than
// [RQ18] Priority pair updated whole before interrupt
`timescale 1ns/1ns
`default_nettype none
module adcps_top #(
  parameter int NCH = 16
) (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic [2:0]                  tap_sel,
  input  wire logic                        normal_start,
  input  wire logic                        repeat_mode,
  input  wire logic                        scan_mode,
  input  wire logic [adcps_pkg::CH_W-1:0]  normal_channel,
  input  wire logic [1:0]                  interrupt_timing_field,
  input  wire logic                        priority_start_bit,
  input  wire logic [1:0]                  trigger_select,
  input  wire logic [adcps_pkg::TRIG_W-1:0] hw_trigger,
  input  wire logic [adcps_pkg::CH_W-1:0]  priority_channel_field,
  input  wire logic                        monitor_enable_bit,
  input  wire logic                        monitor_polarity_bit,
  input  wire logic [adcps_pkg::PAIR_W-1:0] monitor_select,
  input  wire logic [adcps_pkg::RES_W-1:0] compare_value,
  input  wire logic                        priority_end_read,
  input  wire logic [adcps_pkg::RES_W-1:0] analog_result,
  output logic                             sample_start,
  output logic [adcps_pkg::CH_W-1:0]       sample_channel,
  output adcps_pkg::adcps_store_s          result_store,
  output logic                             result_store_valid,
  output logic [adcps_pkg::RES_W-1:0]      priority_result_pair,
  output logic                             priority_end_flag,
  output logic                             priority_busy_flag,
  output logic                             normal_busy,
  output logic                             priority_interrupt,
  output logic                             conversion_done_interrupt,
  output logic                             monitor_interrupt,
  output logic                             monitor_flags_set
);
  import adcps_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SYNC = 4'h2,
    ST_CONV = 4'h4,
    ST_STORE = 4'h8
  } adcps_state_e;

  adcps_state_e state_reg, state_next;
  logic             tick;
  logic [1:0]       tcnt_reg;
  logic             is_prio_reg;
  logic             prio_pend_reg;
  logic [CH_W-1:0]  ch_reg;
  logic [2:0]       seq_reg;
  logic             run_reg;
  logic             first_reg;
  logic [TRIG_W-1:0] trig_s1_reg, trig_s2_reg, trig_s3_reg;
  logic             hw_edge, prio_req, conv_done, fixed_rep;
  logic [PAIR_W-1:0] store_pair;
  logic [2:0]       last_seq;
  logic             seq_wrap, scan_wrap, cycle_end;
  logic [CH_W-1:0]  next_ch;
  logic             mon_hit;
  logic             conv_enter;

  adcps_prescaler u_presc (
    .clk     (clk),
    .reset   (reset),
    .tap_sel (tap_sel),
    .tick    (tick)
  );

  // Trigger pins pass two flops; third stage is for edge detection only
  always_ff @(posedge clk) begin
    if (reset) begin
      trig_s1_reg <= '0;
      trig_s2_reg <= '0;
      trig_s3_reg <= '0;
    end else begin
      trig_s1_reg <= hw_trigger;
      trig_s2_reg <= trig_s1_reg;
      trig_s3_reg <= trig_s2_reg;
    end
  end

  // Priority request decode
  assign hw_edge  = trig_s2_reg[trigger_select] & ~trig_s3_reg[trigger_select]; // RQ1
  assign prio_req = priority_start_bit | hw_edge; // RQ1
  assign conv_done = (state_reg == ST_CONV) && tick && (tcnt_reg == 2'(CONV_TICKS - 1)); // RQ9
  assign fixed_rep = repeat_mode & ~scan_mode;
  assign last_seq  = (interrupt_timing_field == ITM_EVERY4) ? LAST_PAIR4 :
                     (interrupt_timing_field == ITM_EVERY8) ? LAST_PAIR8 : 3'h0;
  assign seq_wrap  = (seq_reg == last_seq);
  // Placement: sequential in fixed repeat, else channel modulo eight
  assign store_pair = fixed_rep ? seq_reg : ch_reg[PAIR_W-1:0]; // RQ13 RQ14
  assign scan_wrap = (ch_reg == CH_W'(NCH - 1)) || (ch_reg >= normal_channel);
  assign cycle_end = scan_mode ? scan_wrap : (fixed_rep ? seq_wrap : 1'b1); // RQ16
  assign next_ch   = (scan_mode && !scan_wrap) ? ch_reg + 4'h1 : (scan_mode ? '0 : ch_reg);
  // Monitor compare, greater when polarity is one
  assign mon_hit = monitor_polarity_bit ? (analog_result > compare_value)
                                        : (analog_result < compare_value); // RQ17
  // Sample launch on every entry into conversion, with or without sync
  assign conv_enter = (state_next == ST_CONV) && (state_reg != ST_CONV);

  // Next state of the sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      // Only the first normal step and every priority step pay the sync delay
      ST_IDLE: begin
        if (prio_pend_reg || (run_reg && first_reg)) state_next = ST_SYNC; // RQ12
        else if (run_reg) state_next = ST_CONV; // RQ12
      end
      // First tick aligns to the conversion clock, then full periods follow
      ST_SYNC:  if (tick && tcnt_reg == 2'(FIRST_TICKS)) state_next = ST_CONV; // RQ12
      ST_CONV:  if (conv_done) state_next = ST_STORE;
      ST_STORE: state_next = ST_IDLE;
    endcase
  end

  // Sequencer registers; sync and a single conversion are the only stall points
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      tcnt_reg <= 2'h0;
      is_prio_reg <= 1'b0;
      prio_pend_reg <= 1'b0;
      ch_reg <= '0;
      seq_reg <= 3'h0;
      run_reg <= 1'b0;
      first_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) tcnt_reg <= 2'h0;
      else if (tick) tcnt_reg <= tcnt_reg + 2'h1;
      // Triggers dropped while a priority conversion is pending or running
      if (prio_req && !prio_pend_reg && !is_prio_reg) prio_pend_reg <= 1'b1; // RQ5
      if (normal_start && !run_reg) begin
        run_reg <= 1'b1;
        ch_reg <= scan_mode ? '0 : normal_channel;
        seq_reg <= 3'h0;
      end
      // Only a pending request is consumed; a trigger in this cycle is dropped
      if (state_reg == ST_IDLE && state_next == ST_SYNC && prio_pend_reg) begin
        is_prio_reg <= 1'b1; // RQ2
        prio_pend_reg <= 1'b0;
      end
      if (state_reg == ST_STORE) begin
        if (is_prio_reg) begin
          is_prio_reg <= 1'b0; // RQ4
        end else begin
          // Advance past the stored step so resume continues from there
          ch_reg <= next_ch; // RQ4
          seq_reg <= (fixed_rep && !seq_wrap) ? seq_reg + 3'h1 : 3'h0; // RQ13
          if (cycle_end && !repeat_mode) run_reg <= 1'b0;
        end
      end
      // A fresh run needs sync once; later steps follow back to back
      if (!run_reg) first_reg <= 1'b1; // RQ12
      else if (conv_enter && !is_prio_reg) first_reg <= 1'b0; // RQ12
    end
  end

  // Front end handshake and stores, all outputs registered
  always_ff @(posedge clk) begin
    if (reset) begin
      sample_start <= 1'b0;
      sample_channel <= '0;
      result_store <= '0;
      result_store_valid <= 1'b0;
      priority_result_pair <= '0;
      priority_end_flag <= 1'b0;
      priority_busy_flag <= 1'b0;
      normal_busy <= 1'b0;
      priority_interrupt <= 1'b0;
      conversion_done_interrupt <= 1'b0;
      monitor_interrupt <= 1'b0;
      monitor_flags_set <= 1'b0;
    end else begin
      sample_start <= conv_enter;
      if (conv_enter) sample_channel <= is_prio_reg ? priority_channel_field : ch_reg;
      result_store_valid <= 1'b0;
      priority_interrupt <= 1'b0;
      conversion_done_interrupt <= 1'b0;
      monitor_interrupt <= 1'b0;
      normal_busy <= run_reg;
      priority_busy_flag <= prio_pend_reg | is_prio_reg;
      // End flag: read clears, a completion in the same cycle wins
      if (priority_end_read) priority_end_flag <= 1'b0;
      if (state_reg == ST_STORE && is_prio_reg) begin
        priority_result_pair <= analog_result; // RQ3 RQ18
        priority_interrupt <= 1'b1; // RQ3
        priority_end_flag <= 1'b1; // RQ15
        priority_busy_flag <= 1'b0; // RQ15
      end else if (state_reg == ST_STORE) begin
        result_store <= '{pair: store_pair, data: analog_result}; // RQ2
        result_store_valid <= 1'b1;
        conversion_done_interrupt <= cycle_end; // RQ16
        // Evaluated only on writes into the watched pair
        if (store_pair == monitor_select) begin
          monitor_interrupt <= monitor_enable_bit & mon_hit; // RQ6 RQ7
          monitor_flags_set <= monitor_enable_bit; // RQ8
        end
      end
    end
  end

  a_prio_pair_int: assert property (@(posedge clk) disable iff (reset)
    priority_interrupt |-> priority_end_flag && !priority_busy_flag) // RQ3
    else $error("priority interrupt without end flag");
  a_prio_ignore: assert property (@(posedge clk) disable iff (reset)
    is_prio_reg && prio_req |=> !prio_pend_reg) // RQ5
    else $error("priority trigger accepted while busy");
  a_conv_ticks: assert property (@(posedge clk) disable iff (reset)
    $rose(state_reg == ST_CONV) |-> (state_reg == ST_CONV) [*2]) // RQ9
    else $error("conversion shorter than two clocks");
  a_mon_only_store: assert property (@(posedge clk) disable iff (reset)
    monitor_interrupt |-> $past(state_reg == ST_STORE && !is_prio_reg)) // RQ7
    else $error("monitor fired outside a store");
  a_mon_enable: assert property (@(posedge clk) disable iff (reset)
    monitor_interrupt |-> $past(monitor_enable_bit)) // RQ6
    else $error("monitor fired while disabled");
  a_pair_modulo: assert property (@(posedge clk) disable iff (reset)
    state_reg == ST_STORE && !is_prio_reg && !fixed_rep
    |=> result_store.pair == $past(ch_reg[PAIR_W-1:0])) // RQ14
    else $error("pair is not channel modulo eight");
  a_fixed_pair0: assert property (@(posedge clk) disable iff (reset)
    result_store_valid && $past(fixed_rep)
    && $past(interrupt_timing_field) == ITM_EVERY1 |-> result_store.pair == 3'h0) // RQ13
    else $error("fixed repeat every-one not pair zero");
  a_end_read_clear: assert property (@(posedge clk) disable iff (reset)
    priority_end_read && !(state_reg == ST_STORE && is_prio_reg) |=> !priority_end_flag) // RQ15
    else $error("end flag not cleared by read");
endmodule : adcps_top
`default_nettype wire

// file: test/adcps_front_model.sv
// Behavioural analog front end: samples a channel, presents its result
`timescale 1ns/1ns
`default_nettype none
module adcps_front_model (
  input  wire logic                       clk,
  input  wire logic                       reset,
  input  wire logic                       sample_start,
  input  wire logic [adcps_pkg::CH_W-1:0] sample_channel,
  output logic [adcps_pkg::RES_W-1:0]     analog_result
);
  import adcps_pkg::*;
  logic [CH_W-1:0] ch_reg;
  logic [6:0]      age_reg;
  logic            flip_reg;
  logic [RES_W-1:0] value;
  // Age counter: result valid for 127 cycles after sampling, stale after
  always_ff @(posedge clk) begin
    flip_reg <= reset ? 1'b0 : ~flip_reg;
    if (reset) begin
      age_reg <= 7'h7F;
      ch_reg  <= '0;
    end else if (sample_start) begin
      age_reg <= 7'h00;
      ch_reg  <= sample_channel;
    end else if (age_reg != 7'h7F) begin
      age_reg <= age_reg + 7'h01;
    end
  end
  // Stale value toggles so a late sample reads as correct only every other cycle
  assign value = {ch_reg, ~ch_reg, 2'h1};
  assign analog_result = (age_reg != 7'h7F) ? value : value ^ {RES_W{~flip_reg}};
endmodule : adcps_front_model
`default_nettype wire

// file: test/adcps_top_tb_top.sv
// Self-checking bench for the priority, monitor and sequencer block
`timescale 1ns/1ns
`default_nettype none
module adcps_top_tb_top;
  import adcps_pkg::*;
  logic clk = 1'b0, reset = 1'b1, nstart = 1'b0, rep = 1'b0, scan = 1'b0;
  logic pbit = 1'b0, mon_en = 1'b0, mon_pol = 1'b0, end_rd = 1'b0, fixed_ph = 1'b0;
  logic [2:0] tap = 3'h0, mon_sel = 3'h0;
  logic [3:0] nch = 4'h0, pch = 4'h0, hw = 4'h0, s_ch;
  logic [1:0] itf = 2'h0, tsel = 2'h0;
  logic [9:0] cmp = 10'h000, analog, pres;
  logic s_start, s_valid, pend, pbusy, nbusy, pirq, dirq, mirq, mflags;
  adcps_store_s st;
  int err_count = 0, num_checks = 0, mon_cnt = 0, since = 0, per = 1, n, e;
  logic [9:0] prio_q[$];
  adcps_store_s store_q[$];
  always #50 clk = ~clk;
  adcps_top #(.NCH(16)) i_dut (.clk(clk), .reset(reset), .tap_sel(tap), .normal_start(nstart),
    .repeat_mode(rep), .scan_mode(scan), .normal_channel(nch), .interrupt_timing_field(itf),
    .priority_start_bit(pbit), .trigger_select(tsel), .hw_trigger(hw),
    .priority_channel_field(pch), .monitor_enable_bit(mon_en), .monitor_polarity_bit(mon_pol),
    .monitor_select(mon_sel), .compare_value(cmp), .priority_end_read(end_rd),
    .analog_result(analog), .sample_start(s_start), .sample_channel(s_ch), .result_store(st),
    .result_store_valid(s_valid), .priority_result_pair(pres), .priority_end_flag(pend),
    .priority_busy_flag(pbusy), .normal_busy(nbusy), .priority_interrupt(pirq),
    .conversion_done_interrupt(dirq), .monitor_interrupt(mirq), .monitor_flags_set(mflags));
  adcps_front_model i_front (.clk(clk), .reset(reset), .sample_start(s_start),
    .sample_channel(s_ch), .analog_result(analog));
  function automatic logic [9:0] fe(input logic [3:0] c);
    return {c, ~c, 2'h1};
  endfunction : fe
  task automatic check(input string nm, input logic [15:0] ex, input logic [15:0] got);
    num_checks++;
    if (got !== ex) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask : check
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // Scoreboard: oldest note taken off whenever a result shows
  always @(posedge clk) if (!reset) begin
    if (pirq) begin
      check("prio_note", 16'h1, 16'(prio_q.size() != 0));
      if (prio_q.size() != 0) check("prio_pair", 16'(prio_q.pop_front()), 16'(pres));
      check("end_busy", 16'h2, {14'h0, pend, pbusy});
    end
    if (s_valid && store_q.size() == 0) check("store_note", 16'h1, 16'h0);
    else if (s_valid) check("store", 16'(store_q.pop_front()), 16'(st));
    if (mirq) mon_cnt++;
    if (dirq && fixed_ph) check("irq_spacing", 16'(per), 16'(since + int'(s_valid)));
    if (dirq && fixed_ph) since = 0;
    else if (s_valid) since++;
  end
  // One priority conversion, a refused second request, then read clear
  task automatic prio_run(input logic [3:0] c, input logic by_hw);
    @(posedge clk);
    pch <= c;
    prio_q.push_back(fe(c));
    if (by_hw) hw[tsel] <= 1'b1;
    else pbit <= 1'b1;
    @(posedge clk);
    pbit <= 1'b0;
    // Second software request lands while the first is pending or running
    for (n = 1; n < 2000 && !pend; n++) begin
      @(posedge clk);
      pbit <= 1'(n == 4);
    end
    hw <= 4'h0;
    // Latency from an idle start; a scan makes it wait for the current step
    if (!by_hw && !scan)
      check("latency", 16'h1, 16'(n >= 4 << tap && n <= (5 << tap) + 6));
    @(posedge clk);
    end_rd <= 1'b1;
    @(posedge clk);
    end_rd <= 1'b0;
    #1 check("end_clear", 16'h0, 16'(pend));
    repeat (100) @(posedge clk);
    check("no_extra", 16'h0, 16'(prio_q.size()));
  endtask : prio_run
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'hA61596FF));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    // Every prescaler tap by software, then every trigger source; fast taps prove the divider only
    for (int t = 0; t < 5; t++) begin
      tap <= 3'(t);
      prio_run(4'($urandom), 1'b0);
    end
    for (int s = 0; s < 4; s++) begin
      tsel <= 2'(s);
      prio_run(4'($urandom), 1'b1);
    end
    // Scan 0..9 interrupted by a priority request, monitor watching pair 1
    // Conversion clock held at or under the accuracy limit from here on
    tap <= TAP_DIV8;
    mon_en <= 1'b1;
    mon_sel <= 3'h1;
    scan <= 1'b1;
    nch <= 4'h9;
    for (int p = 0; p < 2; p++) begin
      mon_pol <= p[0];
      cmp <= 10'($urandom);
      mon_cnt = 0;
      @(posedge clk);
      for (int c = 0; c < 10; c++) store_q.push_back({3'(c), fe(4'(c))});
      nstart <= 1'b1;
      @(posedge clk);
      nstart <= 1'b0;
      for (int i = 0; i < 500 && store_q.size() > 6; i++) @(posedge clk);
      prio_run(4'($urandom), 1'b0);
      for (int i = 0; i < 900 && nbusy; i++) @(posedge clk);
      check("resume", 16'h0, 16'(store_q.size()));
      e = p ? int'(fe(4'h1) > cmp) + int'(fe(4'h9) > cmp) : int'(fe(4'h1) < cmp) + int'(fe(4'h9) < cmp);
      check("mon_count", 16'(e), 16'(mon_cnt));
    end
    check("mon_flags", 16'h1, 16'(mflags));
    // Fixed channel repeat: pair order and interrupt spacing per timing code
    mon_en <= 1'b0;
    scan <= 1'b0;
    nch <= 4'h5;
    for (int m = 0; m < 3; m++) begin
      itf <= 2'(m);
      rep <= 1'b1;
      fixed_ph <= 1'b1;
      per = (m == 0) ? 1 : (m == 1) ? 4 : 8;
      since = 0;
      for (int k = 0; k < 24; k++) store_q.push_back({3'(k % per), fe(4'h5)});
      @(posedge clk);
      nstart <= 1'b1;
      @(posedge clk);
      nstart <= 1'b0;
      for (int i = 0; i < 3000 && store_q.size() > 8; i++) @(posedge clk);
      check("repeat_run", 16'h8, 16'(store_q.size()));
      // Stop in the gap after a store; the last step is then a fixed single
      @(posedge clk);
      rep <= 1'b0;
      fixed_ph <= 1'b0;
      store_q.delete();
      store_q.push_back({3'h5, fe(4'h5)});
      for (int i = 0; i < 900 && (nbusy || i < 2); i++) @(posedge clk);
      check("repeat_stop", 16'h0, 16'(store_q.size()));
    end
    report_and_stop();
  end
endmodule : adcps_top_tb_top
`default_nettype wire
